// File: hw/fpeg_guard.sv
// Flash programming/erasing guard: interface registers, error flag and protection
`timescale 1ns/10ps
module fpeg_guard (
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   input  wire logic                  hw_standby,
   input  wire logic [5:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire fpeg_pkg::fpeg_events_t events,
   input  wire fpeg_pkg::fpeg_mode_t  mode_pins,
   input  wire logic                  serial1_rx,
   output logic                       serial1_tx,
   output logic                       copy_active,
   output logic                       op_active,
   output logic                       error_protect,
   output logic                       boot_array_sel,
   output logic      [2:0]            op_mode
);
   logic [7:0]  system_timer_control, next_system_timer_control;
   logic [7:0]  pcs, next_pcs;
   logic [7:0]  ecs, next_ecs;
   logic [7:0]  key_code, next_key_code;
   logic [7:0]  array_select, next_array_select;
   logic [7:0]  tdar, next_tdar;
   logic [7:0]  ccs_rsv, next_ccs_rsv;
   logic        error_flag, next_error_flag;
   logic [7:0]  copy_cnt, next_copy_cnt;
   fpeg_pkg::fpeg_state_t state, next_state;
   logic [31:0] next_readdata;
   logic        ack, next_ack;
   logic        done_copy, next_done_copy;
   logic [2:0]  mode_q, next_mode_q;
   logic        strap_taken, next_strap_taken;
   logic        tx_q, next_tx_q;
   logic        next_copy_active;
   logic        next_op_active;
   logic        next_boot_sel;
   logic        next_waitreq;
   logic        iface_en;
   logic        req;
   logic        wr_low;
   logic        any_event;
   logic        init_regs;
   logic [7:0]  wbyte;
   logic [7:0]  ccs_read;

   assign init_regs = reset | hw_standby;
   assign req       = (avs_read | avs_write) & ~ack;
   assign wr_low    = avs_write & req & avs_byteenable[0];
   assign wbyte     = avs_writedata[7:0];
   assign iface_en  = system_timer_control[fpeg_pkg::SYSTEM_TIMER_CONTROL_EN_BIT];
   assign any_event = events.irq | events.flash_read | events.sleep | events.other_master;

   always_comb begin
      ccs_read = ccs_rsv;
      ccs_read[fpeg_pkg::CCS_WE_BIT]   = 1'b1;
      ccs_read[fpeg_pkg::CCS_ERR_BIT]  = error_flag;
      ccs_read[fpeg_pkg::CCS_COPY_BIT] = 1'b0;
   end

   // Register bus: one wait cycle, then acknowledge
   always_comb begin
      next_system_timer_control         = system_timer_control;
      next_pcs          = pcs;
      next_ecs          = ecs;
      next_key_code     = key_code;
      next_array_select = array_select;
      next_tdar         = tdar;
      next_ccs_rsv      = ccs_rsv;
      next_ack          = req;
      next_readdata     = fpeg_pkg::WORD_ZERO;
      if (wr_low && avs_address == fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL) begin
         next_system_timer_control = wbyte;
      end
      if (wr_low && iface_en) begin
         unique case (avs_address)
            fpeg_pkg::ADDR_CCS:  begin
               next_ccs_rsv = wbyte & fpeg_pkg::CCS_RSV_MASK;
            end
            fpeg_pkg::ADDR_PCS:  next_pcs = wbyte;
            fpeg_pkg::ADDR_ECS:  next_ecs = wbyte;
            fpeg_pkg::ADDR_KEY:  next_key_code = wbyte;
            fpeg_pkg::ADDR_MATS: next_array_select = wbyte;
            fpeg_pkg::ADDR_TDAR: next_tdar = wbyte;
            default: ;
         endcase
      end
      if (done_copy) begin
         next_pcs = fpeg_pkg::BYTE_ZERO;
         next_ecs = fpeg_pkg::BYTE_ZERO;
      end
      if (avs_read && req) begin
         if (avs_address == fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL) begin
            next_readdata[7:0] = system_timer_control;
         end else if (iface_en) begin
            unique case (avs_address)
               fpeg_pkg::ADDR_CCS:  next_readdata[7:0] = ccs_read;
               fpeg_pkg::ADDR_PCS:  next_readdata[7:0] = pcs;
               fpeg_pkg::ADDR_ECS:  next_readdata[7:0] = ecs;
               fpeg_pkg::ADDR_KEY:  next_readdata[7:0] = key_code;
               fpeg_pkg::ADDR_MATS: next_readdata[7:0] = array_select;
               fpeg_pkg::ADDR_TDAR: next_readdata[7:0] = tdar;
               fpeg_pkg::ADDR_STAT: next_readdata[2:0] = {error_protect, op_active, copy_active};
               default: ;
            endcase
         end
      end
      next_boot_sel = (next_array_select == fpeg_pkg::MATS_BOOT);
      next_waitreq  = ~next_ack;
   end

   // Sequencer and error flag
   always_comb begin
      next_state      = state;
      next_copy_cnt   = copy_cnt;
      next_done_copy  = 1'b0;
      next_error_flag = error_flag;
      unique case (state)
         fpeg_pkg::FPEG_IDLE: begin
            if (wr_low && iface_en && avs_address == fpeg_pkg::ADDR_CCS
                && wbyte[fpeg_pkg::CCS_COPY_BIT] && key_code == fpeg_pkg::KEY_DOWNLOAD) begin
               next_state    = fpeg_pkg::FPEG_COPY;
               next_copy_cnt = fpeg_pkg::COPY_CYCLES;
            end
            // start needs program key and no error
            else if (wr_low && iface_en && avs_address == fpeg_pkg::ADDR_PEOP
                && (wbyte[fpeg_pkg::PEOP_PROG_BIT] || wbyte[fpeg_pkg::PEOP_ERASE_BIT])
                && key_code == fpeg_pkg::KEY_PROGRAM && !error_flag) begin
               next_state = fpeg_pkg::FPEG_OPER;
            end
         end
         fpeg_pkg::FPEG_COPY: begin
            next_copy_cnt = copy_cnt - 8'h01;
            if (copy_cnt == 8'h01) begin
               next_state     = fpeg_pkg::FPEG_IDLE;
               next_done_copy = 1'b1;
            end
         end
         fpeg_pkg::FPEG_OPER: begin
            // operation ends by software or on error
            if (error_flag || (wr_low && iface_en && avs_address == fpeg_pkg::ADDR_PEOP
                && wbyte[1:0] == 2'b00)) begin
               next_state = fpeg_pkg::FPEG_IDLE;
            end
         end
         default: next_state = fpeg_pkg::FPEG_IDLE;
      endcase
      // events judged only while in progress
      if (state == fpeg_pkg::FPEG_OPER && any_event) begin
         next_error_flag = 1'b1;
      end
      next_copy_active = (next_state == fpeg_pkg::FPEG_COPY);
      next_op_active   = (next_state == fpeg_pkg::FPEG_OPER);
   end

   // Strap capture after reset release and serial loader echo of rx in boot mode, idle line otherwise
   always_comb begin
      next_mode_q      = mode_q;
      next_strap_taken = 1'b1;
      next_tx_q        = 1'b1;
      if (!strap_taken) begin
         next_mode_q = {mode_pins.mode_select_2, mode_pins.mode_select_1,
                        mode_pins.mode_select_0};
      end
      if (mode_q == fpeg_pkg::MODE_BOOT) begin
         next_tx_q = serial1_rx;
      end
   end

   always_ff @(posedge clk) begin
      if (init_regs) begin
         system_timer_control            <= fpeg_pkg::SYSTEM_TIMER_CONTROL_RESET;
         pcs             <= fpeg_pkg::BYTE_ZERO;
         ecs             <= fpeg_pkg::BYTE_ZERO;
         key_code        <= fpeg_pkg::BYTE_ZERO;
         array_select    <= fpeg_pkg::MATS_USER;
         tdar            <= fpeg_pkg::BYTE_ZERO;
         ccs_rsv         <= fpeg_pkg::BYTE_ZERO;
         error_flag      <= 1'b0;
         copy_cnt        <= fpeg_pkg::BYTE_ZERO;
         state           <= fpeg_pkg::FPEG_IDLE;
         ack             <= 1'b0;
         avs_readdata    <= fpeg_pkg::WORD_ZERO;
         done_copy       <= 1'b0;
         mode_q          <= fpeg_pkg::MODE_RESET;
         strap_taken     <= 1'b0;
         tx_q            <= 1'b1;
         copy_active     <= 1'b0;
         op_active       <= 1'b0;
         boot_array_sel  <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else if (clk_en) begin
         system_timer_control            <= next_system_timer_control;
         pcs             <= next_pcs;
         ecs             <= next_ecs;
         key_code        <= next_key_code;
         array_select    <= next_array_select;
         tdar            <= next_tdar;
         ccs_rsv         <= next_ccs_rsv;
         error_flag      <= next_error_flag;
         copy_cnt        <= next_copy_cnt;
         state           <= next_state;
         ack             <= next_ack;
         avs_readdata    <= next_readdata;
         done_copy       <= next_done_copy;
         mode_q          <= next_mode_q;
         strap_taken     <= next_strap_taken;
         tx_q            <= next_tx_q;
         copy_active     <= next_copy_active;
         op_active       <= next_op_active;
         boot_array_sel  <= next_boot_sel;
         avs_waitrequest <= next_waitreq;
      end
   end

   always_comb error_protect   = error_flag;
   always_comb op_mode         = mode_q;
   always_comb serial1_tx      = tx_q;

   property p_err_sets;
      @(posedge clk) disable iff (init_regs)
      (clk_en && op_active && any_event) |=> error_flag;
   endproperty
   a_err_sets: assert property (p_err_sets) else $error("event in operation not flagged");

   property p_err_sticky;
      @(posedge clk) disable iff (init_regs) error_flag |=> error_flag;
   endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared early");

   property p_no_idle_err;
      @(posedge clk) disable iff (init_regs)
      (!op_active && !error_flag) |=> !error_flag;
   endproperty
   a_no_idle_err: assert property (p_no_idle_err) else $error("error set outside operation");

   property p_protect;
      @(posedge clk) disable iff (init_regs)
      (error_flag && !op_active) |=> !op_active;
   endproperty
   a_protect: assert property (p_protect) else $error("operation started under protection");

   sequence s_copy_start;
      clk_en && !copy_active ##1 copy_active;
   endsequence
   property p_copy_key;
      @(posedge clk) disable iff (init_regs)
      s_copy_start |-> $past(key_code) == fpeg_pkg::KEY_DOWNLOAD;
   endproperty
   a_copy_key: assert property (p_copy_key) else $error("copy without download key");

   property p_copy_ends;
      @(posedge clk) disable iff (init_regs)
      (clk_en && $rose(copy_active)) |-> ##[1:40] !copy_active;
   endproperty
   a_copy_ends: assert property (p_copy_ends) else $error("copy did not complete");

   property p_ack;
      @(posedge clk) disable iff (init_regs)
      (clk_en && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered");

   property p_gate;
      @(posedge clk) disable iff (init_regs)
      (clk_en && avs_read && avs_waitrequest && !iface_en
       && avs_address != fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL) |=> avs_readdata == fpeg_pkg::WORD_ZERO;
   endproperty
   a_gate: assert property (p_gate) else $error("register read while disabled");

   property p_we_bit;
      @(posedge clk) disable iff (init_regs)
      (clk_en && avs_read && avs_waitrequest && iface_en && avs_address == fpeg_pkg::ADDR_CCS)
      |=> avs_readdata[fpeg_pkg::CCS_WE_BIT] && !avs_readdata[fpeg_pkg::CCS_COPY_BIT];
   endproperty
   a_we_bit: assert property (p_we_bit) else $error("control status read image wrong");
endmodule

// File: hw/fpeg_pkg.sv
// Package for the flash programming/erasing guard: register map, fields, keys and states
package fpeg_pkg;
   // Register byte addresses on the Avalon-MM slave (word index times four)
   localparam logic [5:0] ADDR_CCS      = 6'h00;
   localparam logic [5:0] ADDR_PCS      = 6'h04;
   localparam logic [5:0] ADDR_ECS      = 6'h08;
   localparam logic [5:0] ADDR_KEY      = 6'h0C;
   localparam logic [5:0] ADDR_MATS     = 6'h10;
   localparam logic [5:0] ADDR_TDAR     = 6'h14;
   localparam logic [5:0] ADDR_PEOP     = 6'h18;
   localparam logic [5:0] ADDR_STAT     = 6'h1C;
   localparam logic [5:0] ADDR_SYSTEM_TIMER_CONTROL     = 6'h20;
   // Control status register fields
   localparam int         CCS_WE_BIT    = 7;
   localparam int         CCS_ERR_BIT   = 4;
   localparam int         CCS_COPY_BIT  = 0;
   localparam int         SYSTEM_TIMER_CONTROL_EN_BIT   = 3;
   localparam int         PEOP_PROG_BIT = 0;
   localparam int         PEOP_ERASE_BIT = 1;
   localparam logic [7:0] KEY_DOWNLOAD  = 8'hA5;
   localparam logic [7:0] KEY_PROGRAM   = 8'h5A;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [7:0] SYSTEM_TIMER_CONTROL_RESET    = 8'h00;
   localparam logic [7:0] MATS_USER     = 8'h00;
   localparam logic [7:0] MATS_BOOT     = 8'hAA;
   // Reserved control status bits that keep what software writes
   localparam logic [7:0] CCS_RSV_MASK  = 8'h6E;
   // Strap code of boot mode and strap register reset value
   localparam logic [2:0] MODE_BOOT     = 3'h2;
   localparam logic [2:0] MODE_RESET    = 3'h0;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   // Download length in clocks, a plain default
   localparam logic [7:0] COPY_CYCLES   = 8'h10;
   typedef enum logic [1:0] {
      FPEG_IDLE = 2'b00,
      FPEG_COPY = 2'b01,
      FPEG_OPER = 2'b10
   } fpeg_state_t;
   // Events that corrupt an operation in progress
   typedef struct packed {
      logic irq;
      logic flash_read;
      logic sleep;
      logic other_master;
   } fpeg_events_t;
   // Strap inputs
   typedef struct packed {
      logic mode_select_2;
      logic mode_select_1;
      logic mode_select_0;
   } fpeg_mode_t;
endpackage

// File: verif/fpeg_cpu_model.sv
// Bus master and event source standing in for the CPU and other masters
`timescale 1ns/10ps
module fpeg_cpu_model (
   input  wire logic              clk,
   output logic      [5:0]        avs_address,
   output logic                   avs_read,
   output logic                   avs_write,
   output logic      [31:0]       avs_writedata,
   output logic      [3:0]        avs_byteenable,
   input  wire logic [31:0]       avs_readdata,
   input  wire logic              avs_waitrequest,
   output fpeg_pkg::fpeg_events_t events
);
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      events = 4'h0;
   end
   // caller passes assigned items, zero reserved bits, keys
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h00_0000, d};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released data does not keep its last value
      avs_writedata <= ~{24'h00_0000, d};
   endtask
   // One-cycle pulse of event i, 0 being the interrupt
   task automatic pulse(input int i);
      @(posedge clk);
      events <= 4'h8 >> i;
      @(posedge clk);
      events <= 4'h0;
   endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the flash programming/erasing guard
`timescale 1ns/10ps
module testbench;
   logic                   clk;
   logic                   reset;
   logic                   hw_standby;
   logic [5:0]             avs_address;
   logic                   avs_read;
   logic                   avs_write;
   logic [31:0]            avs_writedata;
   logic [3:0]             avs_byteenable;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   fpeg_pkg::fpeg_events_t events;
   fpeg_pkg::fpeg_mode_t   mode_pins;
   logic                   serial1_rx;
   logic                   serial1_tx;
   logic                   boot_array_sel;
   logic                   clk_en;
   logic                   copy_active;
   logic                   op_active;
   logic                   error_protect;
   logic [2:0]             op_mode;
   logic [31:0]            q;
   int                     err_total = 0;
   int                     n_compared = 0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   fpeg_cpu_model fpeg_cpu_model_inst (.clk(clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .events(events));
   fpeg_guard fpeg_guard_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
      .hw_standby(hw_standby), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .events(events), .mode_pins(mode_pins),
      .serial1_rx(serial1_rx), .serial1_tx(serial1_tx), .copy_active(copy_active),
      .op_active(op_active), .error_protect(error_protect),
      .boot_array_sel(boot_array_sel),
      .op_mode(op_mode));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      fpeg_cpu_model_inst.bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input string m);
      fpeg_cpu_model_inst.bus(1'b0, a, 8'h00, q);
      check(q, {24'h00_0000, e}, m);
   endtask
   task automatic do_rst(input int n, input logic stby);
      @(posedge clk);
      if (stby) hw_standby <= 1'b1;
      else reset <= 1'b1;
      repeat (n) @(posedge clk);
      reset <= 1'b0;
      hw_standby <= 1'b0;
   endtask
   task automatic t_access;
      rd(fpeg_pkg::ADDR_CCS, 8'h00, "ccs while disabled");
      wr(fpeg_pkg::ADDR_KEY, 8'h5A);
      wr(fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL, 8'h08);
      rd(fpeg_pkg::ADDR_KEY, 8'h00, "key write while disabled");
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "ccs initial");
      wr(fpeg_pkg::ADDR_CCS, 8'h00);
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "write enable stays 1");
      wr(fpeg_pkg::ADDR_TDAR, 8'hC3);
      rd(fpeg_pkg::ADDR_TDAR, 8'hC3, "byte register");
      rd(6'h24, 8'h00, "unmapped");
      check({29'h0, op_mode}, {29'h0, fpeg_pkg::MODE_BOOT}, "mode straps");
      @(posedge clk);
      serial1_rx <= 1'b0;
      repeat (3) @(posedge clk);
      check({31'h0, serial1_tx}, 32'h0, "boot serial echo");
      serial1_rx <= 1'b1;
   endtask
   task automatic t_copy;
      wr(fpeg_pkg::ADDR_PCS, 8'h01);
      wr(fpeg_pkg::ADDR_CCS, 8'h01);
      rd(fpeg_pkg::ADDR_STAT, 8'h00, "copy without key");
      wr(fpeg_pkg::ADDR_KEY, fpeg_pkg::KEY_DOWNLOAD);
      wr(fpeg_pkg::ADDR_CCS, 8'h01);
      rd(fpeg_pkg::ADDR_STAT, 8'h01, "copy running");
      check({31'h0, copy_active}, 32'h1, "copy level");
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "copy bit reads 0");
      repeat (20) @(posedge clk);
      rd(fpeg_pkg::ADDR_STAT, 8'h00, "copy done");
      rd(fpeg_pkg::ADDR_PCS, 8'h00, "select cleared");
   endtask
   task automatic t_oper;
      wr(fpeg_pkg::ADDR_PEOP, 8'h01);
      rd(fpeg_pkg::ADDR_STAT, 8'h00, "op with download key");
      wr(fpeg_pkg::ADDR_KEY, fpeg_pkg::KEY_PROGRAM);
      wr(fpeg_pkg::ADDR_MATS, fpeg_pkg::MATS_BOOT);
      check({31'h0, boot_array_sel}, 32'h1, "boot array");
      wr(fpeg_pkg::ADDR_PEOP, 8'h02);
      rd(fpeg_pkg::ADDR_STAT, 8'h02, "erase running");
      check({31'h0, op_active}, 32'h1, "op level");
      // Low clock enable freezes state, so an event is not seen
      @(posedge clk);
      clk_en <= 1'b0;
      fpeg_cpu_model_inst.pulse(0);
      @(posedge clk);
      clk_en <= 1'b1;
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "event while frozen");
      wr(fpeg_pkg::ADDR_PEOP, 8'h00);
      fpeg_cpu_model_inst.pulse(0);
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "event outside op");
   endtask
   task automatic t_error(input int i);
      do_rst(3, i[0]);
      wr(fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL, 8'h08);
      rd(fpeg_pkg::ADDR_KEY, 8'h00, "key after reset");
      wr(fpeg_pkg::ADDR_KEY, fpeg_pkg::KEY_PROGRAM);
      wr(fpeg_pkg::ADDR_PEOP, 8'h01);
      rd(fpeg_pkg::ADDR_STAT, 8'h02, "program running");
      fpeg_cpu_model_inst.pulse(i);
      rd(fpeg_pkg::ADDR_CCS, 8'h90, "error flag set");
      check({31'h0, error_protect}, 32'h1, "protect level");
      wr(fpeg_pkg::ADDR_PEOP, 8'h01);
      rd(fpeg_pkg::ADDR_STAT, 8'h04, "protection blocks op");
      // long reset hold after an error
      do_rst(2500, 1'b0);
      wr(fpeg_pkg::ADDR_SYSTEM_TIMER_CONTROL, 8'h08);
      rd(fpeg_pkg::ADDR_CCS, 8'h80, "error cleared by reset");
      check({31'h0, error_protect}, 32'h0, "protect released");
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      hw_standby = 1'b0;
      clk_en = 1'b1;
      mode_pins = fpeg_pkg::MODE_BOOT;
      serial1_rx = 1'b1;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_access();
      t_copy();
      t_oper();
      for (int i = 0; i < 4; i++) t_error(i);
      conclude();
   end
   initial begin
      #(40 * 30000);
      err_total++;
      conclude();
   end
endmodule
